/* rtl/csts_pkg.sv */
package csts_pkg;

    // ==========================================================
    // Clock and time base
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned TICK_PERIOD_MS = 1000;
    localparam int unsigned TICK_CYCLES = (CLK_HZ / 1000) * TICK_PERIOD_MS;
    localparam int unsigned SEC_PER_MIN = 60;
    localparam int unsigned SEC_PER_HR = 3600;

    // ==========================================================
    // Safety timeout periods, counted in one-second ticks
    localparam int unsigned PRE_MIN_0 = 40;
    localparam int unsigned PRE_MIN_1 = 60;
    localparam int unsigned PRE_MIN_2 = 80;
    localparam int unsigned TOT_HR_0 = 3;
    localparam int unsigned TOT_HR_1 = 4;
    localparam int unsigned TOT_HR_2 = 5;
    localparam int TIMER_W = 16;
    localparam logic [TIMER_W-1:0] PRE_TICKS_0 = TIMER_W'(PRE_MIN_0 * SEC_PER_MIN);
    localparam logic [TIMER_W-1:0] PRE_TICKS_1 = TIMER_W'(PRE_MIN_1 * SEC_PER_MIN);
    localparam logic [TIMER_W-1:0] PRE_TICKS_2 = TIMER_W'(PRE_MIN_2 * SEC_PER_MIN);
    localparam logic [TIMER_W-1:0] TOT_TICKS_0 = TIMER_W'(TOT_HR_0 * SEC_PER_HR);
    localparam logic [TIMER_W-1:0] TOT_TICKS_1 = TIMER_W'(TOT_HR_1 * SEC_PER_HR);
    localparam logic [TIMER_W-1:0] TOT_TICKS_2 = TIMER_W'(TOT_HR_2 * SEC_PER_HR);
    localparam logic [1:0] SEL_40_OR_3 = 2'h0;
    localparam logic [1:0] SEL_60_OR_4 = 2'h1;
    localparam logic [1:0] SEL_80_OR_5 = 2'h2;
    localparam logic [1:0] SEL_OFF = 2'h3;

    // ==========================================================
    // Register map
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_TIMER_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_TEMP_CTRL = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
    localparam int TIMER_CTRL_W = 7;
    localparam int TEMP_CTRL_W = 3;
    localparam logic [TIMER_CTRL_W-1:0] TIMER_CTRL_RESET = 7'h00;
    localparam logic [TEMP_CTRL_W-1:0] TEMP_CTRL_RESET = 3'h0;
    localparam int ST_TIMER_FLAG = 0;
    localparam int ST_TEMP_FLAG = 1;
    localparam int ST_TIMER_FAULT = 2;
    localparam int ST_TEMP_OK = 3;
    localparam int ST_STATE_LSB = 4;
    localparam int ST_REVERSE = 11;

    // ==========================================================
    // Types
    typedef struct packed {
        logic timer_stat_en;
        logic total_expiry_irq_en;
        logic precond_expiry_irq_en;
        logic [1:0] total_timeout_sel;
        logic [1:0] precond_timeout_sel;
    } csts_timer_ctrl_t;

    typedef struct packed {
        logic temp_stat_en;
        logic temp_return_irq_en;
        logic temp_exit_irq_en;
    } csts_temp_ctrl_t;

    typedef struct packed {
        logic supply_valid;
        logic battery_present;
        logic vbat_above_precond;
        logic vbat_at_term;
        logic current_at_eoc;
        logic vbat_recharge;
        logic ntc_hot;
        logic ntc_cold;
        logic supply_below_bat;
    } csts_sense_t;

    typedef enum logic [6:0] {
        ST_PRECOND = 7'h01,
        ST_FAST = 7'h02,
        ST_TOPOFF = 7'h04,
        ST_EOC = 7'h08,
        ST_SUSPEND = 7'h10,
        ST_TEMP_FAULT = 7'h20,
        ST_TIMEOUT = 7'h40
    } csts_state_t;

endpackage : csts_pkg

/* rtl/csts_rate_tick.sv */
// Emits one tick per nominal second at full charge rate; a lower rate
// stretches the interval in inverse proportion.
module csts_rate_tick import csts_pkg::*; #(
    parameter int unsigned TICK_CYCLES = csts_pkg::TICK_CYCLES,
    parameter int RATE_W = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    input wire logic [RATE_W-1:0] rate,
    output logic tick
);
    localparam logic [47:0] FULL = 48'(TICK_CYCLES) * 48'((1 << RATE_W) - 1);

    logic [47:0] acc;
    logic [47:0] next_acc;

    assign next_acc = acc + 48'(rate);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc <= 48'h0;
            tick <= 1'b0;
        end else if (!run) begin
            acc <= 48'h0;
            tick <= 1'b0;
        end else if (next_acc >= FULL) begin
            acc <= next_acc - FULL;
            tick <= 1'b1;
        end else begin
            acc <= next_acc;
            tick <= 1'b0;
        end
    end

endmodule : csts_rate_tick

/* rtl/csts_charger_timer.sv */
// How it works
// - Precondition timeout select: 00=40 min, 01=60, 10=80, 11=timer off.
// - Total timeout select: 00=3 h, 01=4 h, 10=5 h, 11=timer off.
// - Reduced charge current slows the timer tick, stretching timeouts proportionally.
// - Precondition expiry flags interrupt only with its enable and timer-status enable.
// - Total expiry flags interrupt only with its enable and timer-status enable.
// - Timer fault level reads 1 after any timeout, else 0.
// - Timer interrupt flag reads 1 once raised, cleared by reading it.
// - LED output sinks in precondition, fast and top-off; released otherwise.
// - Charging suspends while thermistor sense is outside hot/cold window.
// - Temperature exit flags interrupt only with its enable and status enable.
// - Temperature return flags interrupt only with its enable and status enable.
// - Temperature level reads 1 inside valid range, 0 outside.
// - Temperature interrupt flag reads 1 once raised, cleared by reading it.
// - Supply below battery switches charge path into low battery-drain mode.
// - Precondition timeout moves the charge state machine to timeout fault.
// - Total timeout in fast or top-off gives end-of-charge; recharge on droop.
//
// Decided for this implementation: the plain strobed port and the address map.
module csts_charger_timer import csts_pkg::*; #(
    parameter int unsigned TICK_CYCLES = csts_pkg::TICK_CYCLES,
    parameter int RATE_W = 8
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    input wire csts_sense_t SENSE,
    input wire logic [RATE_W-1:0] CHG_RATE,
    output logic CHARGE_EN,
    output logic REVERSE_BLOCK,
    output logic IRQ,
    output logic CHARGE_ACTIVE_LED_N_O,
    output logic CHARGE_ACTIVE_LED_N_OE_N
);

    // ==========================================================
    // Registers and state
    csts_timer_ctrl_t timer_ctrl;
    csts_temp_ctrl_t temp_ctrl;
    csts_state_t state;
    csts_state_t next_state;
    logic [TIMER_W-1:0] pre_count;
    logic [TIMER_W-1:0] tot_count;
    logic [TIMER_W-1:0] pre_limit;
    logic [TIMER_W-1:0] tot_limit;
    logic tick;
    logic charging;
    logic pre_exp;
    logic tot_exp;
    logic temp_ok;
    logic temp_ok_d;
    logic temp_exit;
    logic temp_return;
    logic timer_irq_flag;
    logic temp_irq_flag;
    logic timer_fault_level;
    logic status_read;
    logic timer_set;
    logic temp_set;

    assign charging = (state == ST_PRECOND) || (state == ST_FAST) || (state == ST_TOPOFF);
    assign temp_ok = !SENSE.ntc_hot && !SENSE.ntc_cold;
    assign status_read = RD && (ADDR == OFS_STATUS);

    // ==========================================================
    // Register writes
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            timer_ctrl <= TIMER_CTRL_RESET;
            temp_ctrl <= TEMP_CTRL_RESET;
        end else if (WR && ADDR == OFS_TIMER_CTRL) begin
            timer_ctrl <= WDATA[TIMER_CTRL_W-1:0];
        end else if (WR && ADDR == OFS_TEMP_CTRL) begin
            temp_ctrl <= WDATA[TEMP_CTRL_W-1:0];
        end
    end

    // ==========================================================
    // Safety timers
    csts_rate_tick #(.TICK_CYCLES(TICK_CYCLES), .RATE_W(RATE_W)) u_tick (
        .clk(CLK),
        .rst(SYS_RST),
        .run(charging),
        .rate(CHG_RATE),
        .tick(tick)
    );

    always_comb begin
        case (timer_ctrl.precond_timeout_sel)
            SEL_40_OR_3: pre_limit = PRE_TICKS_0;
            SEL_60_OR_4: pre_limit = PRE_TICKS_1;
            SEL_80_OR_5: pre_limit = PRE_TICKS_2;
            default: pre_limit = PRE_TICKS_0;
        endcase
        case (timer_ctrl.total_timeout_sel)
            SEL_40_OR_3: tot_limit = TOT_TICKS_0;
            SEL_60_OR_4: tot_limit = TOT_TICKS_1;
            SEL_80_OR_5: tot_limit = TOT_TICKS_2;
            default: tot_limit = TOT_TICKS_0;
        endcase
    end

    assign pre_exp = (state == ST_PRECOND) && (timer_ctrl.precond_timeout_sel != SEL_OFF) && tick
        && (pre_count == pre_limit - 1'b1);
    assign tot_exp = ((state == ST_FAST) || (state == ST_TOPOFF)) && (timer_ctrl.total_timeout_sel != SEL_OFF)
        && tick && (tot_count >= tot_limit - 1'b1);

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pre_count <= '0;
        end else if (state != ST_PRECOND) begin
            pre_count <= '0;
        end else if (tick && pre_count != pre_limit) begin
            pre_count <= pre_count + 1'b1;
        end
    end

    // Total timer spans precondition too, so it starts with the cycle
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            tot_count <= '0;
        end else if (!charging) begin
            tot_count <= '0;
        end else if (tick && tot_count != tot_limit) begin
            tot_count <= tot_count + 1'b1;
        end
    end

    // ==========================================================
    // Charge state machine
    always_comb begin
        next_state = state;
        if (!SENSE.supply_valid || !SENSE.battery_present) begin
            next_state = ST_SUSPEND;
        end else if (!temp_ok && state != ST_TIMEOUT) begin
            next_state = ST_TEMP_FAULT;
        end else begin
            case (state)
                ST_PRECOND: begin
                    if (pre_exp) begin
                        next_state = ST_TIMEOUT;
                    end else if (SENSE.vbat_above_precond) begin
                        next_state = ST_FAST;
                    end
                end
                ST_FAST: begin
                    if (tot_exp) begin
                        next_state = ST_EOC;
                    end else if (SENSE.vbat_at_term) begin
                        next_state = ST_TOPOFF;
                    end
                end
                ST_TOPOFF: begin
                    if (tot_exp || SENSE.current_at_eoc) begin
                        next_state = ST_EOC;
                    end
                end
                ST_EOC: begin
                    if (SENSE.vbat_recharge) begin
                        next_state = ST_PRECOND;
                    end
                end
                ST_SUSPEND: next_state = ST_PRECOND;
                ST_TEMP_FAULT: next_state = ST_PRECOND;
                ST_TIMEOUT: next_state = ST_TIMEOUT;
                default: next_state = ST_SUSPEND;
            endcase
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state <= ST_SUSPEND;
        end else begin
            state <= next_state;
        end
    end

    // ==========================================================
    // Timer and temperature status
    assign timer_set = timer_ctrl.timer_stat_en
        && ((pre_exp && timer_ctrl.precond_expiry_irq_en)
        || (tot_exp && timer_ctrl.total_expiry_irq_en));
    assign temp_exit = temp_ok_d && !temp_ok;
    assign temp_return = !temp_ok_d && temp_ok;
    assign temp_set = temp_ctrl.temp_stat_en
        && ((temp_exit && temp_ctrl.temp_exit_irq_en)
        || (temp_return && temp_ctrl.temp_return_irq_en));

    // A fault stays visible until a fresh charge cycle begins
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            timer_fault_level <= 1'b0;
        end else if (pre_exp || tot_exp) begin
            timer_fault_level <= 1'b1;
        end else if (next_state == ST_PRECOND && state != ST_PRECOND) begin
            timer_fault_level <= 1'b0;
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            temp_ok_d <= 1'b1;
        end else begin
            temp_ok_d <= temp_ok;
        end
    end

    // Set beats the read clear so an event in the read cycle is kept
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            timer_irq_flag <= 1'b0;
            temp_irq_flag <= 1'b0;
        end else begin
            if (timer_set) begin
                timer_irq_flag <= 1'b1;
            end else if (status_read) begin
                timer_irq_flag <= 1'b0;
            end
            if (temp_set) begin
                temp_irq_flag <= 1'b1;
            end else if (status_read) begin
                temp_irq_flag <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Read port
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            RDATA <= 32'h0;
        end else if (!RD) begin
            RDATA <= 32'h0;
        end else begin
            case (ADDR)
                OFS_TIMER_CTRL: RDATA <= {25'h0, timer_ctrl};
                OFS_TEMP_CTRL: RDATA <= {29'h0, temp_ctrl};
                OFS_STATUS: begin
                    RDATA <= 32'h0;
                    RDATA[ST_TIMER_FLAG] <= timer_irq_flag;
                    RDATA[ST_TEMP_FLAG] <= temp_irq_flag;
                    RDATA[ST_TIMER_FAULT] <= timer_fault_level;
                    RDATA[ST_TEMP_OK] <= temp_ok;
                    RDATA[ST_STATE_LSB +: 7] <= state;
                    RDATA[ST_REVERSE] <= REVERSE_BLOCK;
                end
                default: RDATA <= 32'h0;
            endcase
        end
    end

    // ==========================================================
    // Outputs
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            CHARGE_EN <= 1'b0;
            REVERSE_BLOCK <= 1'b0;
            IRQ <= 1'b0;
            CHARGE_ACTIVE_LED_N_O <= 1'b0;
            CHARGE_ACTIVE_LED_N_OE_N <= 1'b1;
        end else begin
            CHARGE_EN <= charging;
            REVERSE_BLOCK <= SENSE.supply_below_bat;
            IRQ <= timer_irq_flag || temp_irq_flag;
            CHARGE_ACTIVE_LED_N_O <= 1'b0;
            CHARGE_ACTIVE_LED_N_OE_N <= !charging;
        end
    end

    // ==========================================================
    // Checks
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    pre_off_a: assert property (timer_ctrl.precond_timeout_sel == SEL_OFF |-> !pre_exp)
        else $error("precondition timer expired while off");
    tot_off_a: assert property (timer_ctrl.total_timeout_sel == SEL_OFF |-> !tot_exp)
        else $error("total timer expired while off");
    pre_fault_a: assert property (pre_exp && SENSE.supply_valid && SENSE.battery_present && temp_ok
        |=> state == ST_TIMEOUT && timer_fault_level)
        else $error("precondition timeout did not fault");
    tot_eoc_a: assert property (tot_exp && SENSE.supply_valid && SENSE.battery_present && temp_ok
        |=> state == ST_EOC)
        else $error("total timeout did not end charge");
    timer_flag_a: assert property (timer_ctrl.timer_stat_en && timer_ctrl.precond_expiry_irq_en && pre_exp
        |=> timer_irq_flag ##1 IRQ)
        else $error("precondition expiry not flagged");
    timer_gate_a: assert property (!timer_irq_flag && !timer_ctrl.timer_stat_en |=> !timer_irq_flag)
        else $error("timer flag set without status enable");
    flag_clear_a: assert property (status_read && !timer_set && !temp_set
        |=> !timer_irq_flag && !temp_irq_flag)
        else $error("flags not cleared by read");
    temp_flag_a: assert property (temp_ctrl.temp_stat_en && temp_ctrl.temp_exit_irq_en && temp_exit
        |=> temp_irq_flag)
        else $error("temperature exit not flagged");
    temp_suspend_a: assert property (!temp_ok && SENSE.supply_valid && SENSE.battery_present
        && state != ST_TIMEOUT |=> !charging ##1 CHARGE_ACTIVE_LED_N_OE_N)
        else $error("charging during temperature fault");
    led_state_a: assert property (1'b1 |=> CHARGE_ACTIVE_LED_N_OE_N == !$past(charging))
        else $error("led drive does not follow state");
    irq_level_a: assert property (!timer_irq_flag && !temp_irq_flag |=> !IRQ)
        else $error("interrupt request without a flag");

    // ==========================================================
    // Read-back, output, flag and state checks
    temp_return_a: assert property (temp_ctrl.temp_stat_en && temp_ctrl.temp_return_irq_en && temp_return
        |=> temp_irq_flag)
        else $error("temperature return not flagged");
    temp_level_a: assert property (status_read
        |=> RDATA[ST_TEMP_OK] == !$past(SENSE.ntc_hot || SENSE.ntc_cold))
        else $error("temperature level misreported");
    timer_read_a: assert property (status_read && timer_irq_flag |=> RDATA[ST_TIMER_FLAG])
        else $error("timer flag lost on read");
    temp_read_a: assert property (status_read && temp_irq_flag |=> RDATA[ST_TEMP_FLAG])
        else $error("temperature flag lost on read");
    reverse_a: assert property (1'b1 |=> REVERSE_BLOCK == $past(SENSE.supply_below_bat))
        else $error("reverse block does not follow supply");
    timeout_hold_a: assert property (state == ST_TIMEOUT && SENSE.supply_valid && SENSE.battery_present
        |=> state == ST_TIMEOUT)
        else $error("timeout fault left while powered");
    rdata_idle_a: assert property (!RD |=> RDATA == 32'h0)
        else $error("read data outside a read cycle");

endmodule : csts_charger_timer

/* bench/csts_host_model.sv */
// ==========================================================
// Host side of the register bus: one-cycle strobes, read data a cycle later
module csts_host_model import csts_pkg::*; (
    input wire logic clk,
    output logic [ADDR_W-1:0] addr,
    output logic [31:0] wdata,
    output logic wr,
    output logic rd,
    input wire logic [31:0] rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
    end

    // Idle address and data are inverted so nothing stale looks valid
    task automatic write_reg(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask : write_reg

    task automatic read_reg(input logic [ADDR_W-1:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
        #1 d = rdata;
    endtask : read_reg
endmodule : csts_host_model

/* bench/csts_charger_timer_tb.sv */
module csts_charger_timer_tb import csts_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    // Short tick keeps hour-long timeouts within the run
    localparam int unsigned TCYC = 2;
    logic clk, sys_rst, chg_en, rev_blk, irq, led_o, led_oe_n;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata, rdata, d, wv;
    logic wr, rd;
    logic [7:0] rate;
    logic [2:0] te;
    csts_sense_t sense;
    int errors, n_checks, cyc, lim, per;
    int pre_s[4] = '{40 * 60, 60 * 60, 80 * 60, 0};

    csts_charger_timer #(.TICK_CYCLES(TCYC)) csts_charger_timer_i (
        .CLK(clk), .SYS_RST(sys_rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .SENSE(sense), .CHG_RATE(rate), .CHARGE_EN(chg_en),
        .REVERSE_BLOCK(rev_blk), .IRQ(irq), .CHARGE_ACTIVE_LED_N_O(led_o),
        .CHARGE_ACTIVE_LED_N_OE_N(led_oe_n)
    );
    csts_host_model host_i (
        .clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata)
    );

    // ==========================================================
    // Checking helpers
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    function automatic logic [31:0] st_word(csts_state_t s, logic tf, logic mf, logic fl, logic ok);
        return {21'h0, s, ok, fl, mf, tf};
    endfunction : st_word

    task automatic check_status(input string what, input logic [31:0] exp);
        host_i.read_reg(OFS_STATUS, d);
        chk(what, exp, d);
    endtask : check_status

    task automatic at(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : at

    // Brief supply loss restarts a charge cycle through suspend
    task automatic pulse_suspend();
        @(posedge clk) sense.supply_valid <= 1'b0;
        @(posedge clk) sense.supply_valid <= 1'b1;
    endtask : pulse_suspend

    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    // ==========================================================
    // Clock, reset, watchdog
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 100000) begin
            errors++;
            $display("BAD watchdog expected finish seen timeout");
            finish_test();
        end
    end

    // ==========================================================
    // Test sequence
    initial begin
        sys_rst = 1'b1;
        rate = 8'hff;
        sense = '0;
        sense.supply_valid = 1'b1;
        sense.battery_present = 1'b1;
        void'($urandom(32'h9f0b));
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;

        // Reset values, register access, unmapped place
        at(3);
        chk("charge_en", 1, chg_en);
        chk("led_o", 0, led_o);
        chk("led_oe_n", 0, led_oe_n);
        chk("irq", 0, irq);
        host_i.read_reg(OFS_TIMER_CTRL, d);
        chk("timer_ctrl", 0, d);
        host_i.read_reg(OFS_TEMP_CTRL, d);
        chk("temp_ctrl", 0, d);
        check_status("status", st_word(ST_PRECOND, 0, 0, 0, 1));
        wv = $urandom;
        host_i.write_reg(OFS_TIMER_CTRL, wv);
        host_i.read_reg(OFS_TIMER_CTRL, d);
        chk("timer_ctrl", wv & 32'h7f, d);
        at(1);
        chk("rdata idle", 0, rdata);
        host_i.write_reg(8'h0c, $urandom);
        host_i.read_reg(8'h0c, d);
        chk("unmapped", 0, d);
        host_i.read_reg(OFS_TIMER_CTRL, d);
        chk("timer_ctrl", wv & 32'h7f, d);
        $display("test registers done");

        // Precondition timeout per select code, with enable mixes
        for (int i = 0; i < 4; i++) begin
            te = 3'(3 - i);
            host_i.write_reg(OFS_TIMER_CTRL, {25'h0, te[1], 1'b0, te[0], 2'h3, 2'(i)});
            rate <= (i == 0) ? 8'd85 : 8'd255;
            pulse_suspend();
            check_status("precond entry", st_word(ST_PRECOND, 0, 0, 0, 1));
            per = TCYC * 255 / ((i == 0) ? 85 : 255);
            lim = (i == 3) ? 9600 : pre_s[i] * per;
            at(lim - 64);
            chk("charge_en early", 1, chg_en);
            at(120);
            chk("charge_en late", (i == 3), chg_en);
            chk("led_oe_n", (i != 3), led_oe_n);
            if (i < 3) begin
                chk("irq", (te == 3), irq);
                check_status("timeout", st_word(ST_TIMEOUT, (te == 3), 0, 1, 1));
                check_status("timeout reread", st_word(ST_TIMEOUT, 0, 0, 1, 1));
            end
        end
        @(posedge clk);
        rate <= 8'hff;
        $display("test precondition timer done");

        // Total timeout to end-of-charge, recharge, disabled total timer
        sense.vbat_above_precond <= 1'b1;
        host_i.write_reg(OFS_TIMER_CTRL, 32'h63);
        pulse_suspend();
        at(3 * 3600 * TCYC - 60);
        chk("charge_en early", 1, chg_en);
        at(120);
        chk("charge_en late", 0, chg_en);
        chk("led_oe_n", 1, led_oe_n);
        chk("irq", 1, irq);
        check_status("eoc", st_word(ST_EOC, 1, 0, 1, 1));
        at(2);
        chk("irq cleared", 0, irq);
        @(posedge clk) sense.vbat_recharge <= 1'b1;
        at(4);
        chk("recharge", 1, chg_en);
        @(posedge clk) sense.vbat_recharge <= 1'b0;
        check_status("recharged", st_word(ST_FAST, 0, 0, 0, 1));
        host_i.write_reg(OFS_TIMER_CTRL, 32'h6f);
        pulse_suspend();
        at(3 * 3600 * TCYC + 60);
        chk("total off", 1, chg_en);
        $display("test total timer done");

        // Temperature exit and return, random enables
        for (int k = 0; k < 4; k++) begin
            te = 3'($urandom) | ((k == 0) ? 3'h7 : 3'h0);
            host_i.write_reg(OFS_TEMP_CTRL, {29'h0, te});
            @(posedge clk);
            if (k % 2 == 1) sense.ntc_cold <= 1'b1;
            else sense.ntc_hot <= 1'b1;
            at(3);
            chk("charge_en temp", 0, chg_en);
            chk("led_oe_n temp", 1, led_oe_n);
            chk("irq exit", te[2] & te[0], irq);
            check_status("temp out", st_word(ST_TEMP_FAULT, 0, te[2] & te[0], 0, 0));
            @(posedge clk);
            sense.ntc_hot <= 1'b0;
            sense.ntc_cold <= 1'b0;
            at(4);
            chk("charge_en back", 1, chg_en);
            chk("irq return", te[2] & te[1], irq);
            check_status("temp in", st_word(ST_FAST, 0, te[2] & te[1], 0, 1));
        end
        $display("test temperature done");

        // Supply below battery
        @(posedge clk) sense.supply_below_bat <= 1'b1;
        at(3);
        chk("reverse on", 1, rev_blk);
        check_status("reverse status", st_word(ST_FAST, 0, 0, 0, 1) | (32'h1 << ST_REVERSE));
        @(posedge clk) sense.supply_below_bat <= 1'b0;
        at(3);
        chk("reverse off", 0, rev_blk);
        $display("test reverse done");

        // Top-off, then end-of-charge on current taper with no timer fault
        @(posedge clk) sense.vbat_at_term <= 1'b1;
        at(3);
        chk("led_oe_n topoff", 0, led_oe_n);
        check_status("topoff", st_word(ST_TOPOFF, 0, 0, 0, 1));
        @(posedge clk) sense.current_at_eoc <= 1'b1;
        at(3);
        chk("charge_en eoc", 0, chg_en);
        chk("led_oe_n eoc", 1, led_oe_n);
        check_status("eoc by current", st_word(ST_EOC, 0, 0, 0, 1));
        $display("test top-off done");
        finish_test();
    end
endmodule : csts_charger_timer_tb
